/* core/cpdo_fpga.sv */
// Purpose: FPGA loader end; clocks or follows the link and buffers bytes
// Assumes: Mode inputs and byte count are stable while start is high
// Notes: Bytes leave through a 32-entry FIFO with back-pressure
`timescale 1ns/1ps
`default_nettype none
module cpdo_fifo #(
    parameter int W = 8, // Data width
    parameter int DEPTH = 32, // Entries, power of two
    parameter int MARGIN = 4 // Almost-full distance from full
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic in_valid, // Write request
    input wire logic [W-1:0] in_data, // Write data
    output logic in_ready, // Room for a write
    output logic almost_full, // Level at or above DEPTH-MARGIN
    output logic out_valid, // Read data valid
    output logic [W-1:0] out_data, // Read data
    input wire logic out_ready // Read accept
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    typedef struct packed {
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
        logic ov;
        logic [W-1:0] od;
        logic rdy;
        logic af;
    } cpdo_fifo_st_t;

    cpdo_fifo_st_t q;
    cpdo_fifo_st_t n;
    logic [W-1:0] mem [0:DEPTH-1];
    logic push;
    logic pop;

    always_comb begin
        n = q;
        push = in_valid && q.rdy;
        // Refill the output register whenever it empties or is taken
        pop = (q.cnt != '0) && (!q.ov || out_ready);
        if (push) begin
            n.wr = q.wr + PW'(1);
        end
        if (pop) begin
            n.od = mem[q.rd];
            n.ov = 1'b1;
            n.rd = q.rd + PW'(1);
        end else if (out_ready) begin
            n.ov = 1'b0;
        end
        n.cnt = q.cnt + CW'(push) - CW'(pop);
        n.rdy = n.cnt != CW'(DEPTH);
        n.af = n.cnt >= CW'(DEPTH - MARGIN);
        if (sys_rst) begin
            n = '0;
            n.rdy = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= n;
        if (push) begin
            mem[q.wr] <= in_data;
        end
    end

    assign in_ready = q.rdy;
    assign almost_full = q.af;
    assign out_valid = q.ov;
    assign out_data = q.od;
endmodule : cpdo_fifo

module cpdo_fpga
    import cpdo_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic start, // Hold high to load, drop to rearm
    input wire logic master_mode, // Generate the link clock
    input wire logic parallel_mode, // Byte-wide capture
    input wire logic [COUNT_W-1:0] xfer_bytes, // Image length, bytes
    input wire logic [REV_W-1:0] rev_select, // Revision pin value
    output logic [BYTE_W-1:0] out_data, // Captured byte
    output logic out_valid, // Captured byte valid
    input wire logic out_ready, // Downstream accepts byte
    output logic done, // Load complete
    output logic overflow, // Byte lost with FIFO full
    cpdo_link_if.fpga lnk // Link pins
);
    typedef struct packed {
        cpdo_state_t st;
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic ser_s1;
        logic ser_s2;
        logic [BYTE_W-1:0] par_s1;
        logic [BYTE_W-1:0] par_s2;
        logic mst;
        logic par;
        logic [REV_W-1:0] rev;
        logic [COUNT_W-1:0] tot;
        logic [COUNT_W-1:0] rises;
        logic [COUNT_W-1:0] got;
        logic [2:0] hist;
        logic [BYTE_W-1:0] sh;
        logic [2:0] bitc;
        logic [DIV_W-1:0] div;
        logic lvl;
        logic clk_oe;
        logic armed;
        logic rcfg_n;
        logic ce_n;
        logic oe;
        logic busy;
        logic push_v;
        logic [BYTE_W-1:0] push_d;
        logic done;
        logic overflow;
    } cpdo_host_st_t;

    cpdo_host_st_t q;
    cpdo_host_st_t n;
    logic rise;
    logic fall;
    logic fresh;
    logic fifo_rdy;
    logic fifo_af;

    cpdo_fifo #(
        .W(BYTE_W),
        .DEPTH(FIFO_DEPTH),
        .MARGIN(BUSY_MARGIN)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(q.push_v),
        .in_data(q.push_d),
        .in_ready(fifo_rdy),
        .almost_full(fifo_af),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_ready(out_ready)
    );

    always_comb begin
        n = q;
        rise = 1'b0;
        fall = 1'b0;
        n.push_v = 1'b0;
        n.ck_s1 = lnk.config_clock;
        n.ck_s2 = q.ck_s1;
        n.ck_s3 = q.ck_s2;
        n.ser_s1 = lnk.serial_line;
        n.ser_s2 = q.ser_s1;
        n.par_s1 = lnk.parallel_line;
        n.par_s2 = q.par_s1;
        // Device moved on at the last edge unless it saw busy then
        fresh = (q.rises == COUNT_W'(LEAD_EDGES)) || !q.hist[2];
        case (q.st)
            CPDO_IDLE: begin
                n.rcfg_n = 1'b0;
                n.ce_n = 1'b1;
                n.oe = 1'b0;
                n.busy = 1'b0;
                n.lvl = 1'b0;
                n.clk_oe = 1'b0;
                n.done = 1'b0;
                if (start) begin
                    n.st = CPDO_RUN;
                    n.rcfg_n = 1'b1;
                    n.ce_n = 1'b0;
                    n.oe = 1'b1;
                    n.mst = master_mode;
                    n.par = parallel_mode;
                    n.rev = rev_select;
                    n.tot = parallel_mode ? xfer_bytes :
                        {xfer_bytes[COUNT_W-4:0], 3'b000};
                    n.rises = '0;
                    n.got = '0;
                    n.hist = '0;
                    n.bitc = '0;
                    n.div = '0;
                    n.armed = master_mode;
                    n.clk_oe = master_mode;
                    n.overflow = 1'b0;
                end
            end
            CPDO_RUN: begin
                if (q.mst) begin
                    if (q.div == DIV_W'(CONFIG_CLOCK_HALF_CYC - 1)) begin
                        n.div = '0;
                        if (q.lvl) begin
                            n.lvl = 1'b0;
                            fall = 1'b1;
                        end else if (fifo_rdy) begin
                            // Stalling the clock is the master's brake
                            n.lvl = 1'b1;
                            rise = 1'b1;
                        end
                    end else begin
                        n.div = q.div + DIV_W'(1);
                    end
                end else begin
                    rise = q.ck_s2 && !q.ck_s3;
                    fall = !q.ck_s2 && q.ck_s3;
                    // Detected rises lag the pin; count only rises that
                    // came after the enables were already on the pins
                    if (q.div == DIV_W'(SYNC_STAGES - 1)) begin
                        n.armed = 1'b1;
                    end
                    if (!q.armed) begin
                        n.div = q.div + DIV_W'(1);
                    end
                end
                if (rise && q.armed) begin
                    n.rises = q.rises + COUNT_W'(1);
                    n.hist = {q.hist[1:0], q.busy};
                end
                if (fall) begin
                    n.busy = !q.mst && q.par && fifo_af;
                    if (q.rises >= COUNT_W'(LEAD_EDGES) && fresh) begin
                        n.got = q.got + COUNT_W'(1);
                        if (q.par) begin
                            n.push_v = 1'b1;
                            n.push_d = q.par_s2;
                        end else begin
                            n.sh = {q.sh[BYTE_W-2:0], q.ser_s2};
                            n.bitc = q.bitc + 3'(1);
                            if (q.bitc == BIT_LAST) begin
                                n.push_v = 1'b1;
                                n.push_d = {q.sh[BYTE_W-2:0], q.ser_s2};
                            end
                        end
                        if (n.push_v && !fifo_rdy) begin
                            n.overflow = 1'b1;
                        end
                        if (q.got + COUNT_W'(1) == q.tot) begin
                            n.st = CPDO_DONE;
                        end
                    end
                end
            end
            CPDO_DONE: begin
                n.ce_n = 1'b1;
                n.oe = 1'b0;
                n.busy = 1'b0;
                n.lvl = 1'b0;
                n.clk_oe = 1'b0;
                n.done = 1'b1;
                if (!start) begin
                    n.st = CPDO_IDLE;
                end
            end
            default: begin
                n.st = CPDO_IDLE;
            end
        endcase
        if (sys_rst) begin
            n = '0;
            n.ce_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= n;
    end

    assign lnk.host_clk_drive = q.lvl;
    assign lnk.host_clk_oe = q.clk_oe;
    assign lnk.reconfig_request_n = q.rcfg_n;
    assign lnk.chip_enable_n = q.ce_n;
    assign lnk.reset_oe_n = q.oe;
    assign lnk.busy = q.busy;
    assign lnk.rev_pins = q.rev;
    assign done = q.done;
    assign overflow = q.overflow;
endmodule : cpdo_fpga
`default_nettype wire

/* core/cpdo_pkg.sv */
// Purpose: Shared constants and types of the configuration stream link
// Assumes: 100 MHz system clock on both ends
// Notes: A storage word is a 2-bit tag above one data byte
package cpdo_pkg;
    localparam int CLK_PERIOD_PS = 10000;
    localparam int CONFIG_CLOCK_MAX_KHZ = 33000;
    localparam int CONFIG_CLOCK_MIN_PERIOD_PS = 1000000000 / CONFIG_CLOCK_MAX_KHZ;
    localparam int CONFIG_CLOCK_HALF_RATE =
        (CONFIG_CLOCK_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
    localparam int SYNC_STAGES = 2;
    // Half period must also cover the far end's synchroniser
    localparam int CONFIG_CLOCK_HALF_CYC = (CONFIG_CLOCK_HALF_RATE > SYNC_STAGES) ?
        CONFIG_CLOCK_HALF_RATE : SYNC_STAGES + 1;
    localparam int DIV_W = 4;
    // Link edges before the first item is on the data pins
    localparam int LEAD_EDGES = SYNC_STAGES + 1;
    localparam int DENSITY_MBIT = 32;
    localparam int ADDR_W = $clog2(DENSITY_MBIT * 1024 * 1024 / 8);
    localparam int REV_W = 2;
    localparam int BYTE_W = 8;
    localparam int TAG_W = 2;
    localparam int WORD_W = TAG_W + BYTE_W;
    localparam int COUNT_W = ADDR_W + 4;
    localparam int FIFO_DEPTH = 32;
    localparam int BUSY_MARGIN = 4;
    localparam logic [TAG_W-1:0] TAG_DATA = 2'h0;
    localparam logic [TAG_W-1:0] TAG_RUN = 2'h1;
    localparam logic [TAG_W-1:0] TAG_END = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [BYTE_W-1:0] LINE_IDLE = 8'hff;
    // Bit positions of the synchronised control pins
    localparam int CTL_RCFG = 3;
    localparam int CTL_CE = 2;
    localparam int CTL_OE = 1;
    localparam int CTL_BUSY = 0;
    // Bit positions of the synchronised configuration levels
    localparam int CFG_RST = 3;
    localparam int CFG_REVSRC = 2;
    localparam int CFG_CMP = 1;
    localparam int CFG_PAR = 0;
    typedef enum logic [1:0] {
        CPDO_IDLE = 2'b00,
        CPDO_RUN = 2'b01,
        CPDO_DONE = 2'b10
    } cpdo_state_t;
endpackage : cpdo_pkg

/* core/cpdo_link_if.sv */
// Purpose: Pins between the configuration memory and the loading FPGA
// Assumes: ext_clock is driven by the bench for slave modes
// Notes: Undriven data lines read as pulled high
`timescale 1ns/1ps
`default_nettype none
interface cpdo_link_if
    import cpdo_pkg::*;
();
    logic ext_clock;
    logic config_clock;
    logic prom_clk_drive;
    logic prom_clk_oe;
    logic host_clk_drive;
    logic host_clk_oe;
    logic reconfig_request_n;
    logic chip_enable_n;
    logic reset_oe_n;
    logic busy;
    logic [REV_W-1:0] rev_pins;
    logic serial_config_out;
    logic serial_oe;
    logic [BYTE_W-1:0] parallel_config_out;
    logic parallel_oe;
    logic serial_line;
    logic [BYTE_W-1:0] parallel_line;

    assign config_clock = prom_clk_oe ? prom_clk_drive :
        (host_clk_oe ? host_clk_drive : ext_clock);
    assign serial_line = serial_oe ? serial_config_out : 1'b1;
    assign parallel_line = parallel_oe ? parallel_config_out : LINE_IDLE;

    modport prom (
        input config_clock, reconfig_request_n, chip_enable_n,
        input reset_oe_n, busy, rev_pins,
        output serial_config_out, serial_oe, parallel_config_out,
        output parallel_oe, prom_clk_drive, prom_clk_oe
    );
    modport fpga (
        input config_clock, serial_line, parallel_line,
        output host_clk_drive, host_clk_oe, reconfig_request_n,
        output chip_enable_n, reset_oe_n, busy, rev_pins
    );
endinterface : cpdo_link_if
`default_nettype wire

/* core/cpdo_prom.sv */
// Purpose: Configuration memory end; streams a stored image to the link
// Assumes: Storage is written only while the link is idle
// Notes: Link logic runs on config_clock, housekeeping on clk
// Functional notes
// - Serial mode: enabled device drives serial output
// - Each rising link edge presents next item
// - Master serial: FPGA generates the link clock
// - FPGA issues exactly the clock pulses needed
// - Slave: external clock; parallel variant may drive
// - Parallel mode: busy low, enabled, drive byte
// - FPGA takes byte on the following edge
// - Free-running clock: busy holds data steady
// - Revision chosen by pins or internal bits
// - Several revisions stored per device or chain
// - Decompressor expands compressed images before output
// - Devices chain to deliver longer or multiple images
// - Advanced features need parallel-capable devices only
// - Link clock rates up to 33 MHz
// - Serial variant: serial modes; parallel adds byte modes
// - Address sequencing covers 1 to 32 Mbit
`timescale 1ns/1ps
`default_nettype none
module cpdo_prom
    import cpdo_pkg::*;
#(
    parameter bit PAR_CAP = 1'b1, // Parallel-capable variant
    parameter int AW = ADDR_W // Byte address width, sets density
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic prog_we, // Storage write strobe
    input wire logic [AW-1:0] prog_addr, // Storage write address
    input wire logic [WORD_W-1:0] prog_data, // Tag and byte
    input wire logic parallel_mode, // Byte-wide output when high
    input wire logic compress_en, // Expand run words
    input wire logic rev_from_bits, // Revision from rev_bits, not pins
    input wire logic [REV_W-1:0] rev_bits, // Internal revision select
    input wire logic drive_clock_en, // Drive the link clock
    output logic next_chip_enable_n, // Cascade enable to next device
    output logic image_done, // Image finished, clk domain
    cpdo_link_if.prom lnk // Link pins
);
    typedef struct packed {
        logic [3:0] cfg;
        logic [REV_W-1:0] irev;
        logic [DIV_W-1:0] div;
        logic lvl;
        logic drv_oe;
        logic done_s1;
        logic done_s2;
    } cpdo_sys_st_t;

    typedef struct packed {
        logic [3:0] ctl_s1;
        logic [3:0] ctl_s2;
        logic [3:0] cfg_s1;
        logic [3:0] cfg_s2;
        logic [REV_W-1:0] rev_s1;
        logic [REV_W-1:0] rev_s2;
        logic [REV_W-1:0] irev_s1;
        logic [REV_W-1:0] irev_s2;
        cpdo_state_t st;
        logic [AW-1:0] addr;
        logic [BYTE_W-1:0] cur;
        logic [BYTE_W-1:0] sh;
        logic [2:0] bitn;
        logic [BYTE_W-1:0] run;
        logic ser;
        logic ser_oe;
        logic [BYTE_W-1:0] par;
        logic par_oe;
        logic ceo_n;
        logic done;
    } cpdo_lnk_st_t;

    cpdo_sys_st_t sq;
    cpdo_sys_st_t next_sq;
    cpdo_lnk_st_t lq;
    cpdo_lnk_st_t next_lq;
    logic [WORD_W-1:0] mem [0:(1 << AW)-1];
    logic active;
    logic par_md;
    logic cmp;
    logic [REV_W-1:0] rev;
    logic [AW-1:0] base;
    logic [AW-1:0] fa;
    logic [WORD_W-1:0] w0;
    logic [WORD_W-1:0] w1;
    logic f_end;
    logic f_pair;
    logic [BYTE_W-1:0] f_byte;
    logic [BYTE_W-1:0] f_run;
    logic [AW-1:0] f_step;
    logic load;

    // Storage port; image layout is the writer's business
    always_ff @(posedge clk) begin
        if (prog_we) begin
            mem[prog_addr] <= prog_data;
        end
    end

    // System side: config capture, clock divider, done crossing
    always_comb begin
        next_sq = sq;
        next_sq.cfg = {sys_rst, rev_from_bits, compress_en, parallel_mode};
        next_sq.irev = rev_bits;
        next_sq.drv_oe = PAR_CAP && drive_clock_en;
        if (sq.div == DIV_W'(CONFIG_CLOCK_HALF_CYC - 1)) begin
            next_sq.div = '0;
            next_sq.lvl = ~sq.lvl;
        end else begin
            next_sq.div = sq.div + DIV_W'(1);
        end
        next_sq.done_s1 = lq.done;
        next_sq.done_s2 = sq.done_s1;
        if (sys_rst) begin
            next_sq.div = '0;
            next_sq.lvl = 1'b0;
            next_sq.drv_oe = 1'b0;
            next_sq.done_s1 = 1'b0;
            next_sq.done_s2 = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        sq <= next_sq;
    end

    // Link side
    always_comb begin
        next_lq = lq;
        load = 1'b0;
        next_lq.ctl_s1 = {lnk.reconfig_request_n, lnk.chip_enable_n,
            lnk.reset_oe_n, lnk.busy};
        next_lq.ctl_s2 = lq.ctl_s1;
        next_lq.cfg_s1 = sq.cfg;
        next_lq.cfg_s2 = lq.cfg_s1;
        next_lq.rev_s1 = lnk.rev_pins;
        next_lq.rev_s2 = lq.rev_s1;
        next_lq.irev_s1 = sq.irev;
        next_lq.irev_s2 = lq.irev_s1;
        active = lq.ctl_s2[CTL_RCFG] && !lq.ctl_s2[CTL_CE] &&
            lq.ctl_s2[CTL_OE];
        // Serial-only variant ignores every advanced feature
        par_md = PAR_CAP && lq.cfg_s2[CFG_PAR];
        cmp = PAR_CAP && lq.cfg_s2[CFG_CMP];
        if (!PAR_CAP) begin
            rev = '0;
        end else if (lq.cfg_s2[CFG_REVSRC]) begin
            rev = lq.irev_s2;
        end else begin
            rev = lq.rev_s2;
        end
        base = {rev, (AW - REV_W)'(0)};
        // Revision pins cross with the enables, so the first fetch
        // must use the live base, not the address parked while idle
        fa = (lq.st == CPDO_IDLE) ? base : lq.addr;
        w0 = mem[fa];
        w1 = mem[fa + AW'(1)];
        f_end = w0[WORD_W-1 -: TAG_W] == TAG_END;
        // Run word: count of extra repeats, data in the next word
        f_pair = cmp && (w0[WORD_W-1 -: TAG_W] == TAG_RUN);
        f_byte = f_pair ? w1[BYTE_W-1:0] : w0[BYTE_W-1:0];
        f_run = f_pair ? w0[BYTE_W-1:0] : '0;
        f_step = f_pair ? AW'(2) : AW'(1);

        if (lq.cfg_s2[CFG_RST] || !active) begin
            next_lq.st = CPDO_IDLE;
            next_lq.addr = base;
            next_lq.ser_oe = 1'b0;
            next_lq.par_oe = 1'b0;
            next_lq.ceo_n = 1'b1;
            next_lq.done = 1'b0;
            next_lq.run = '0;
            next_lq.bitn = '0;
        end else begin
            case (lq.st)
                CPDO_IDLE: begin
                    load = 1'b1;
                end
                CPDO_RUN: begin
                    if (par_md && lq.ctl_s2[CTL_BUSY]) begin
                        next_lq.par = lq.par;
                    end else if (!par_md && lq.bitn != BIT_LAST) begin
                        next_lq.ser = lq.sh[BYTE_W-2];
                        next_lq.sh = {lq.sh[BYTE_W-2:0], 1'b0};
                        next_lq.bitn = lq.bitn + 3'(1);
                    end else if (lq.run != '0) begin
                        // Repeat the held byte without touching storage
                        next_lq.run = lq.run - BYTE_W'(1);
                        next_lq.sh = lq.cur;
                        next_lq.ser = lq.cur[BYTE_W-1];
                        next_lq.bitn = '0;
                    end else begin
                        load = 1'b1;
                    end
                end
                CPDO_DONE: begin
                    next_lq.ceo_n = 1'b0;
                end
                default: begin
                    next_lq.st = CPDO_IDLE;
                end
            endcase
        end

        if (load) begin
            if (f_end) begin
                // Hand the link over to the next device in the chain
                next_lq.st = CPDO_DONE;
                next_lq.ceo_n = 1'b0;
                next_lq.done = 1'b1;
                next_lq.ser_oe = 1'b0;
                next_lq.par_oe = 1'b0;
            end else begin
                next_lq.st = CPDO_RUN;
                next_lq.cur = f_byte;
                next_lq.sh = f_byte;
                next_lq.ser = f_byte[BYTE_W-1];
                next_lq.par = f_byte;
                next_lq.run = f_run;
                next_lq.bitn = '0;
                next_lq.addr = fa + f_step;
                next_lq.ser_oe = !par_md;
                next_lq.par_oe = par_md;
            end
        end
    end

    always_ff @(posedge lnk.config_clock) begin
        lq <= next_lq;
    end

    assign lnk.serial_config_out = lq.ser;
    assign lnk.serial_oe = lq.ser_oe;
    assign lnk.parallel_config_out = lq.par;
    assign lnk.parallel_oe = lq.par_oe;
    assign lnk.prom_clk_drive = sq.lvl;
    assign lnk.prom_clk_oe = sq.drv_oe;
    assign next_chip_enable_n = lq.ceo_n;
    assign image_done = sq.done_s2;
endmodule : cpdo_prom
`default_nettype wire

/* tb/cpdo_asserts.sv */
// Purpose: Link checks beside the two joined ends
// Assumes: Inputs are the link interface signals
// Notes: Enables reach the device 3 link edges late
`timescale 1ns/1ps
`default_nettype none
module cpdo_asserts
    import cpdo_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Reset
    input wire logic config_clock, // Link clock
    input wire logic host_clk_drive, // Loader clock
    input wire logic reconfig_request_n, // Load allowed
    input wire logic chip_enable_n, // Select
    input wire logic reset_oe_n, // Outputs on
    input wire logic busy, // Hold
    input wire logic serial_oe, // Bit drive
    input wire logic parallel_oe, // Byte drive
    input wire logic [BYTE_W-1:0] parallel_config_out // Byte
);
    // Five edges cover sync, register and output stage
    property off_p(logic idle);
        @(posedge config_clock) disable iff (sys_rst)
        idle [*5] |-> !serial_oe && !parallel_oe;
    endproperty
    sequence held_s;
        (busy && parallel_oe) [*4];
    endsequence
    ce_off_a: assert property (off_p(chip_enable_n))
        else $error("drive while deselected");
    oe_off_a: assert property (off_p(!reset_oe_n))
        else $error("drive while outputs off");
    req_off_a: assert property (off_p(!reconfig_request_n))
        else $error("drive without request");
    busy_hold_a: assert property (@(posedge config_clock)
        disable iff (sys_rst) held_s |-> $stable(parallel_config_out))
        else $error("byte moved while busy");
    byte_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
        parallel_oe && $past(parallel_oe) && $changed(parallel_config_out)
        |-> $rose(config_clock)) else $error("byte moved off edge");
    clk_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(host_clk_drive) |-> host_clk_drive [*3])
        else $error("link clock high too short");
    clk_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(host_clk_drive) |-> !host_clk_drive [*3])
        else $error("link clock low too short");
endmodule : cpdo_asserts
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Loads stored images across the joined link
// Assumes: Free-running 125 ns link clock in slave loads
// Notes: Device clock drive stays off
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cpdo_pkg::*;
;
    logic clk = 1'h0, sys_rst = 1'h1, we = 1'h0, par = 1'h0;
    logic cmp = 1'h0, rfb = 1'h0, start = 1'h0, mst = 1'h0;
    logic rdy = 1'h1, ov, dn, ovf, nce, idn;
    logic [1:0] chain_seen;
    logic [ADDR_W-1:0] wa = 22'h0;
    logic [WORD_W-1:0] wd = 10'h0, img_q[$];
    logic [REV_W-1:0] rb = 2'h0, rs = 2'h0;
    logic [COUNT_W-1:0] nb = 26'h0;
    logic [BYTE_W-1:0] od, exp_q[$], got_q[$];
    int fails = 0, samples_checked = 0, cyc = 0;
    cpdo_link_if lnk ();
    initial forever #5 clk = ~clk;
    initial begin
        lnk.ext_clock = 1'h0;
        #3;
        forever #62.5 lnk.ext_clock = ~lnk.ext_clock;
    end
    cpdo_prom cpdo_prom_i (.clk(clk), .sys_rst(sys_rst), .prog_we(we),
        .prog_addr(wa), .prog_data(wd), .parallel_mode(par),
        .compress_en(cmp), .rev_from_bits(rfb), .rev_bits(rb),
        .drive_clock_en(1'h0), .next_chip_enable_n(nce),
        .image_done(idn), .lnk(lnk));
    cpdo_fpga cpdo_fpga_i (.clk(clk), .sys_rst(sys_rst), .start(start),
        .master_mode(mst), .parallel_mode(par), .xfer_bytes(nb),
        .rev_select(rs), .out_data(od), .out_valid(ov), .out_ready(rdy),
        .done(dn), .overflow(ovf), .lnk(lnk));
    cpdo_asserts cpdo_asserts_i (.clk(clk), .sys_rst(sys_rst),
        .config_clock(lnk.config_clock), .busy(lnk.busy),
        .host_clk_drive(lnk.host_clk_drive), .serial_oe(lnk.serial_oe),
        .reconfig_request_n(lnk.reconfig_request_n),
        .chip_enable_n(lnk.chip_enable_n), .reset_oe_n(lnk.reset_oe_n),
        .parallel_oe(lnk.parallel_oe),
        .parallel_config_out(lnk.parallel_config_out));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ov === 1'h1 && rdy === 1'h1)
            got_q.push_back(od);
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic run(input logic [REV_W-1:0] r, input int stall);
        foreach (img_q[i]) begin
            @(posedge clk);
            #1;
            we = 1'h1;
            wa = {r, 20'h0} + ADDR_W'(i);
            wd = img_q[i];
        end
        // Mode levels need time to cross into the link domain
        repeat (40) @(posedge clk);
        #1;
        we = 1'h0;
        nb = COUNT_W'(exp_q.size());
        got_q = {};
        rdy = 1'h0;
        start = 1'h1;
        repeat (stall + 1) @(posedge clk);
        #1;
        rdy = 1'h1;
        for (int i = 0; i < 9000 && dn !== 1'h1; i++)
            @(posedge clk);
        // Chain outputs stand only until the device sees the release
        repeat (12) @(posedge clk);
        chain_seen = {nce, idn};
        repeat (68) @(posedge clk);
        #1;
        start = 1'h0;
        check("count", 16'(got_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i])
            check("byte", 16'(got_q[i]), 16'(exp_q[i]));
    endtask : run
    task automatic scen_serial();
        img_q = {10'h0a5, 10'h03c, 10'h081, 10'h200};
        exp_q = {8'ha5, 8'h3c, 8'h81};
        mst = 1'h1;
        run(2'h0, 0);
        // Short load leaves the device mid-image; both must restart
        exp_q = {8'ha5};
        run(2'h0, 0);
        exp_q = {8'ha5, 8'h3c, 8'h81};
        run(2'h0, 0);
    endtask : scen_serial
    task automatic scen_comp();
        img_q = {10'h102, 10'h05a, 10'h0c3, 10'h200};
        exp_q = {8'h5a, 8'h5a, 8'h5a, 8'hc3};
        cmp = 1'h1;
        rfb = 1'h1;
        rb = 2'h2;
        par = 1'h1;
        run(2'h2, 0);
    endtask : scen_comp
    task automatic scen_slave();
        img_q = {};
        exp_q = {};
        for (int i = 0; i < 40; i++) begin
            img_q.push_back({TAG_DATA, 8'(i * 7)});
            exp_q.push_back(8'(i * 7));
        end
        img_q.push_back({TAG_END, 8'h0});
        mst = 1'h0;
        rfb = 1'h0;
        rs = 2'h1;
        run(2'h1, 800);
        check("overflow", 16'(ovf), 16'h0);
        check("next enable", 16'(chain_seen[1]), 16'h0);
        check("image done", 16'(chain_seen[0]), 16'h1);
    endtask : scen_slave
    initial begin
        // Link side clears itself while the enables stay off
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        scen_serial();
        scen_comp();
        scen_slave();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
